// *** logic/drive_run_command_generator.sv ***
// run-command generator: merges keypad, terminals and link word into
// registered forward/reverse internal run commands
// assumes all inputs synchronous to clk; keys are levels while pressed
`timescale 1ns/100ps

module drive_run_command_generator
  import drive_cmd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [4:0]           generalInput,
  input  wire logic                 fwdTerminal,
  input  wire logic                 revTerminal,
  input  wire fn_code_t [4:0]       inputFunctionCode,
  input  wire fn_code_t             fwdTerminalFunction,
  input  wire fn_code_t             revTerminalFunction,
  input  wire logic                 linkWordWrite,
  input  wire logic [15:0]          linkWordData,
  output logic [15:0]               linkOperationWordRd,
  input  wire logic                 keyRunFwd,
  input  wire logic                 keyRunRev,
  input  wire logic                 keyStop,
  input  wire logic [2:0]           runSourceCode,
  input  wire logic [1:0]           stopKeyPriorityCode,
  input  wire logic [1:0]           accelPatternCode,
  input  wire logic [15:0]          refFrequency,
  input  wire logic [15:0]          startingFrequency,
  input  wire logic [15:0]          stoppingFrequency,
  output logic                      runForward,
  output logic                      runReverse,
  output logic                      linkEnable,
  output logic                      localActive,
  output logic                      runPermitWait,
  output logic                      linearDecelForced,
  output logic [1:0]                decelPattern
);

  // stored state
  logic [15:0]        linkOperationWord;
  key_hold_t          keyHold;
  logic               holdFwd;
  logic               holdRev;
  logic               stopForce;
  logic               permitArmed;

  // decoder inputs and outputs
  logic [6:0]         termLevel;
  logic [6:0]         linkLevel;
  fn_code_t [6:0]     termCode;
  term_funcs_t        termFn;
  term_funcs_t        linkFn;

  // next values
  logic [15:0]        next_linkOperationWord;
  key_hold_t          next_keyHold;
  logic               next_holdFwd;
  logic               next_holdRev;
  logic               next_stopForce;
  logic               next_permitArmed;
  logic               next_runForward;
  logic               next_runReverse;

  // merging wires
  logic               keyFwd;
  logic               keyRev;
  logic               wireFwd;
  logic               wireRev;
  logic               linkFwd;
  logic               linkRev;
  logic               linkRunBits;
  logic               linkSel;
  logic               srcFwd;
  logic               srcRev;
  logic               selFwd;
  logic               selRev;
  logic               bothOn;
  logic               anyCmd;
  logic               stopPrioOn;
  logic               stopHit;
  logic               permitOk;
  logic               freqLow;
  logic               gate;

  // the link word is a plain held register written by the link host
  assign next_linkOperationWord = linkWordWrite ? linkWordData
                                                : linkOperationWord;   // [RULE_05]

  // terminal levels in decoder order: general 1..5, forward, reverse
  assign termLevel = {revTerminal, fwdTerminal, generalInput};
  assign termCode  = {revTerminalFunction, fwdTerminalFunction,
                      inputFunctionCode};                              // [RULE_14]

  // link bits mirror the terminals: 2..6 general, 13 fwd, 14 rev
  assign linkLevel = {linkOperationWord[`LW_XREV_BIT],
                      linkOperationWord[`LW_XFWD_BIT],
                      linkOperationWord[`LW_GEN_HI:`LW_GEN_LO]};       // [RULE_13]

  // one decoder per source, same function codes for both
  terminal_decoder termDecoder (
    .level (termLevel),
    .code  (termCode),
    .funcs (termFn)
  );

  terminal_decoder linkDecoder (
    .level (linkLevel),
    .code  (termCode),
    .funcs (linkFn)
  );                                                                   // [RULE_06]

  // keypad: the hold state is the run command, stop clears it
  assign keyFwd = (keyHold == KEY_FWD);                                // [RULE_01]
  assign keyRev = (keyHold == KEY_REV);

  always_comb begin
    next_keyHold = keyHold;
    unique case (keyHold)
      KEY_IDLE: begin
        if (keyRunFwd && !keyRunRev && !keyStop)
          next_keyHold = KEY_FWD;
        else if (keyRunRev && !keyRunFwd && !keyStop)
          next_keyHold = KEY_REV;
      end
      KEY_FWD: begin
        if (keyStop)
          next_keyHold = KEY_IDLE;                                     // [RULE_01]
      end
      KEY_REV: begin
        if (keyStop)
          next_keyHold = KEY_IDLE;                                     // [RULE_01]
      end
    endcase
  end

  // three-wire: a pulse sets the latch, hold off drops it
  assign next_holdFwd = termFn.hold3wAsg & termFn.hold3w &
                        (termFn.run_forward | holdFwd) & ~termFn.run_reverse;          // [RULE_02]
  assign next_holdRev = termFn.hold3wAsg & termFn.hold3w &
                        (termFn.run_reverse | holdRev) & ~termFn.run_forward;          // [RULE_02]

  // without a hold terminal the commands pass as levels
  assign wireFwd = termFn.hold3wAsg ? (termFn.hold3w & (termFn.run_forward | holdFwd))
                                    : termFn.run_forward;                      // [RULE_03]
  assign wireRev = termFn.hold3wAsg ? (termFn.hold3w & (termFn.run_reverse | holdRev))
                                    : termFn.run_reverse;                      // [RULE_03]

  // link run request: bit 0/1 plus programmable bits 13/14
  assign linkFwd = linkOperationWord[`LW_FWD_BIT] | linkFn.run_forward;        // [RULE_05]
  assign linkRev = linkOperationWord[`LW_REV_BIT] | linkFn.run_reverse;        // [RULE_06]

  // any run bit of the word enables the link path, as does the terminal
  assign linkRunBits = linkOperationWord[`LW_XFWD_BIT] |
                       linkOperationWord[`LW_XREV_BIT] |
                       linkOperationWord[`LW_FWD_BIT]  |
                       linkOperationWord[`LW_REV_BIT];                 // [RULE_07]
  assign linkSel = termFn.linkEn | linkRunBits;                        // [RULE_07]

  // source pick: the alternate pair stays level even under hold
  always_comb begin
    srcFwd = keyFwd;
    srcRev = keyRev;
    if (termFn.srcSwitch) begin
      srcFwd = termFn.fwdAlt;                                          // [RULE_04]
      srcRev = termFn.revAlt;                                          // [RULE_04]
    end else if (runSourceCode == `RUN_SRC_TERM) begin
      srcFwd = wireFwd;
      srcRev = wireRev;
    end
  end

  // local select overrides source code, switch and link enable
  always_comb begin
    selFwd = srcFwd;
    selRev = srcRev;
    if (termFn.localSel) begin
      selFwd = keyFwd;                                                 // [RULE_12]
      selRev = keyRev;                                                 // [RULE_12]
    end else if (linkSel) begin
      selFwd = linkFwd;
      selRev = linkRev;
    end
  end

  // both directions at once would be ambiguous, so neither runs
  assign bothOn = selFwd & selRev;                                     // [RULE_08]
  assign anyCmd = selFwd | selRev;

  // stop key priority: the stop sticks until the request goes away;
  // a fresh stop press wins over the release in the same cycle
  assign stopPrioOn = (stopKeyPriorityCode == `STOP_PRIO_A) ||
                      (stopKeyPriorityCode == `STOP_PRIO_B);           // [RULE_09]
  assign stopHit = stopPrioOn & keyStop;
  assign next_stopForce = stopHit | (stopForce & anyCmd);              // [RULE_09]

  // permit: it must be on while no command is present to arm;
  // a command arriving first never runs until released and redone
  assign next_permitArmed = termFn.permit & (permitArmed | ~anyCmd);   // [RULE_11]
  assign permitOk = ~termFn.permitAsg | (termFn.permit & permitArmed); // [RULE_11]

  // run decision: below start or stop frequency means decelerate out
  assign freqLow = (refFrequency < startingFrequency) ||
                   (refFrequency < stoppingFrequency);                 // [RULE_10]

  assign gate = ~bothOn & ~stopForce & ~stopHit & permitOk & ~freqLow;
  assign next_runForward = selFwd & gate;                              // [RULE_08]
  assign next_runReverse = selRev & gate;                              // [RULE_10]

  // link word register; reset value zero means no link request
  always_ff @(posedge clk) begin
    if (!rst_b)
      linkOperationWord <= `LW_RESET;
    else
      linkOperationWord <= next_linkOperationWord;
  end

  // keypad hold and three-wire latches
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keyHold <= KEY_IDLE;                                             // [RULE_16]
      holdFwd <= 1'b0;                                                 // [RULE_16]
      holdRev <= 1'b0;
    end else begin
      keyHold <= next_keyHold;
      holdFwd <= next_holdFwd;
      holdRev <= next_holdRev;
    end
  end

  // stop and permit interlock state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stopForce   <= 1'b0;
      permitArmed <= 1'b0;
    end else begin
      stopForce   <= next_stopForce;
      permitArmed <= next_permitArmed;
    end
  end

  // internal run commands, registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      runForward <= 1'b0;                                              // [RULE_16]
      runReverse <= 1'b0;                                              // [RULE_16]
    end else begin
      runForward <= next_runForward;
      runReverse <= next_runReverse;
    end
  end

  // status and deceleration pattern; stop priority forces linear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      linkEnable          <= 1'b0;
      localActive         <= 1'b0;
      runPermitWait       <= 1'b0;
      linearDecelForced   <= 1'b0;
      decelPattern        <= `PATTERN_LINEAR;
      linkOperationWordRd <= `LW_RESET;
    end else begin
      linkEnable          <= linkSel & ~termFn.localSel;               // [RULE_12]
      localActive         <= termFn.localSel;
      runPermitWait       <= anyCmd & ~permitOk;
      linearDecelForced   <= next_stopForce;                           // [RULE_09]
      decelPattern        <= next_stopForce ? `PATTERN_LINEAR
                                            : accelPatternCode;        // [RULE_09]
      linkOperationWordRd <= next_linkOperationWord;
    end
  end

endmodule : drive_run_command_generator

// *** logic/drive_cmd_cfg.svh ***
// constants for the drive run-command generator: offsets, codes, widths
// assumes inclusion by bare name from the package and the test bench
//
// Overview of operation
// [RULE_01] keypad run key held until stop key
// [RULE_02] three-wire hold latches forward and reverse pulses
// [RULE_03] no hold terminal means plain two-wire levels
// [RULE_04] alternate forward/reverse commands never latched
// [RULE_05] link word bit 0 forward, bit 1 reverse
// [RULE_06] link bits 13/14 act as forward/reverse terminals
// [RULE_07] any run bit in link word raises enable
// [RULE_08] forward and reverse together force both off
// [RULE_09] stop priority codes 1/3: stop clears, linear
// [RULE_10] reference below start or stop frequency: off
// [RULE_11] run permit must precede the run command
// [RULE_12] local select forces keypad as sole source
// [RULE_13] inputs 1-5 on bits 2-6, fwd 13, rev 14
// [RULE_14] each terminal function set by its code
// [RULE_15] same function on many terminals is ORed
// [RULE_16] run commands and latches registered, sync reset
`ifndef DRIVE_CMD_CFG_SVH
`define DRIVE_CMD_CFG_SVH

`define CODE_W          11
`define FN_OFF_BASE     11'h3E8
`define FN_HOLD3W       11'h006
`define FN_LINK_EN      11'h018
`define FN_LOCAL        11'h023
`define FN_RUN_PERMIT   11'h026
`define FN_SRC_SWITCH   11'h057
`define FN_FWD_ALT      11'h058
`define FN_REV_ALT      11'h059
`define FN_FWD          11'h062
`define FN_REV          11'h063

`define LW_FWD_BIT      0
`define LW_REV_BIT      1
`define LW_GEN_LO       2
`define LW_GEN_HI       6
`define LW_XFWD_BIT     13
`define LW_XREV_BIT     14
`define LW_RESET        16'h0000

`define RUN_SRC_TERM    3'h1
`define STOP_PRIO_A     2'h1
`define STOP_PRIO_B     2'h3
`define PATTERN_LINEAR  2'h0

`endif

// *** logic/drive_cmd_pkg.sv ***
// types shared by the run-command generator and its terminal decoder
// assumes drive_cmd_cfg.svh for widths
`include "drive_cmd_cfg.svh"

package drive_cmd_pkg;

  // decoded terminal functions, already ORed over all terminals; run_forward/run_reverse over the two run terminals only
  typedef struct packed {
    logic hold3w;
    logic hold3wAsg;
    logic linkEn;
    logic localSel;
    logic permit;
    logic permitAsg;
    logic srcSwitch;
    logic fwdAlt;
    logic revAlt;
    logic run_forward;
    logic run_reverse;
  } term_funcs_t;

  typedef logic [`CODE_W-1:0] fn_code_t;

  // keypad hold state
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_FWD,
    KEY_REV
  } key_hold_t;

endpackage : drive_cmd_pkg

// *** logic/terminal_decoder.sv ***
// terminal function decoder: seven levels, seven function codes
// assumes index 0..4 general inputs, 5 forward terminal, 6 reverse
`timescale 1ns/100ps

module terminal_decoder
  import drive_cmd_pkg::*;
(
  input  wire logic [6:0]           level,
  input  wire fn_code_t [6:0]       code,
  output term_funcs_t               funcs
);

  // forward/reverse functions only live on the two run terminals
  localparam logic [6:0] ALL_TERMS = 7'h7F;
  localparam logic [6:0] RUN_TERMS = 7'h60;

  // active-on code n, active-off code n plus base; OR over terminals
  function automatic logic fnActive(input logic [6:0] lvl,
                                    input fn_code_t [6:0] cd,
                                    input fn_code_t fn,
                                    input logic [6:0] allow);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (allow[i] && cd[i] == fn)
        acc = acc | lvl[i];                           // [RULE_15]
      if (allow[i] && cd[i] == fn_code_t'(fn + `FN_OFF_BASE))
        acc = acc | ~lvl[i];                          // [RULE_15]
    end
    return acc;
  endfunction : fnActive

  // whether any terminal carries the function at all
  function automatic logic fnAssigned(input fn_code_t [6:0] cd,
                                      input fn_code_t fn);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (cd[i] == fn || cd[i] == fn_code_t'(fn + `FN_OFF_BASE))
        acc = 1'b1;
    end
    return acc;
  endfunction : fnAssigned

  // per-function decode from each terminal's own code
  assign funcs.hold3w    = fnActive(level, code, `FN_HOLD3W, ALL_TERMS); // [RULE_14]
  assign funcs.hold3wAsg = fnAssigned(code, `FN_HOLD3W);                // [RULE_03]
  assign funcs.linkEn    = fnActive(level, code, `FN_LINK_EN, ALL_TERMS);
  assign funcs.localSel  = fnActive(level, code, `FN_LOCAL, ALL_TERMS);
  assign funcs.permit    = fnActive(level, code, `FN_RUN_PERMIT, ALL_TERMS);
  assign funcs.permitAsg = fnAssigned(code, `FN_RUN_PERMIT);            // [RULE_11]
  assign funcs.srcSwitch = fnActive(level, code, `FN_SRC_SWITCH, ALL_TERMS);
  assign funcs.fwdAlt    = fnActive(level, code, `FN_FWD_ALT, ALL_TERMS);
  assign funcs.revAlt    = fnActive(level, code, `FN_REV_ALT, ALL_TERMS);
  assign funcs.run_forward       = fnActive(level, code, `FN_FWD, RUN_TERMS);    // [RULE_14]
  assign funcs.run_reverse       = fnActive(level, code, `FN_REV, RUN_TERMS);

endmodule : terminal_decoder

// *** testbench/drive_run_checker_assertions.sv ***
// assertions on the run-command generator ports
// assumes one control clock and a synchronous active-low reset
`timescale 1ns/100ps

module drive_run_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        linkWordWrite,
  input wire logic [15:0] linkWordData,
  input wire logic [15:0] linkOperationWordRd,
  input wire logic        keyStop,
  input wire logic [1:0]  stopKeyPriorityCode,
  input wire logic [1:0]  accelPatternCode,
  input wire logic [15:0] refFrequency,
  input wire logic [15:0] startingFrequency,
  input wire logic [15:0] stoppingFrequency,
  input wire logic        runForward,
  input wire logic        runReverse,
  input wire logic        linkEnable,
  input wire logic        localActive,
  input wire logic        linearDecelForced,
  input wire logic [1:0]  decelPattern
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // stop with priority codes 1 and 3; a run bit seen in the word
  sequence stopHit;
    keyStop && stopKeyPriorityCode[0];
  endsequence
  sequence linkAsked;
    |{linkOperationWordRd[14:13], linkOperationWordRd[1:0]} ##1 !localActive;
  endsequence

  both_off_a: assert property (!(runForward && runReverse))
    else $error("forward and reverse run both high");
  reset_clear_a: assert property ($rose(rst_b) |->
    !runForward && !runReverse && linkOperationWordRd == 16'h0000)
    else $error("outputs not cleared by reset");
  word_write_a: assert property (linkWordWrite |=>
    linkOperationWordRd == $past(linkWordData))
    else $error("link word not taken");
  word_hold_a: assert property (!linkWordWrite |=>
    $stable(linkOperationWordRd))
    else $error("link word changed without a write");
  link_bits_a: assert property (linkAsked |-> linkEnable)
    else $error("link enable missing for a set run bit");
  stop_clear_a: assert property (stopHit |=>
    !runForward && !runReverse && linearDecelForced)
    else $error("stop key did not clear the run");
  decel_zero_a: assert property (linearDecelForced |->
    decelPattern == 2'h0)
    else $error("forced stop not linear");
  decel_pass_a: assert property (
    !linearDecelForced && $past(rst_b) |->
    decelPattern == $past(accelPatternCode))
    else $error("pattern not passed through");
  freq_low_a: assert property (refFrequency < startingFrequency ||
    refFrequency < stoppingFrequency |=> !runForward && !runReverse)
    else $error("run with reference below limit");
endmodule : drive_run_checker

bind drive_run_command_generator drive_run_checker chk (.*);

// *** testbench/operator_panel.sv ***
// keypad, terminal and link-host stand-in for the run-command generator
// assumes the bench calls its tasks; drives 1 ns after rising clk
`timescale 1ns/100ps

module operator_panel (
  input  wire logic  clk,
  output logic [4:0]  generalInput,
  output logic        fwdTerminal,
  output logic        revTerminal,
  output logic        keyRunFwd,
  output logic        keyRunRev,
  output logic        keyStop,
  output logic        linkWordWrite,
  output logic [15:0] linkWordData
);
  initial begin
    {generalInput, fwdTerminal, revTerminal} = '0;
    {keyRunFwd, keyRunRev, keyStop, linkWordWrite} = '0;
    linkWordData = 16'h0000;
  end

  // terminal and key levels, all changed together
  task automatic put(input logic [4:0] gi, input logic [1:0] fr,
                     input logic [2:0] keys);
    @(posedge clk);
    #1;
    generalInput = gi;
    {fwdTerminal, revTerminal} = fr;
    {keyRunFwd, keyRunRev, keyStop} = keys;
  endtask : put

  // whole-word write; data inverted after, so a stale read shows
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    #1;
    linkWordWrite = 1'b1;
    linkWordData = w;
    @(posedge clk);
    #1;
    linkWordWrite = 1'b0;
    linkWordData = ~w;
  endtask : send
endmodule : operator_panel

// *** testbench/drive_run_command_generator_test.sv ***
// self-checking bench for the run-command generator
// assumes operator_panel drives keys, terminals and the link word
`timescale 1ns/100ps
`include "drive_cmd_cfg.svh"

// compare, count and report a mismatch at once
`define CHK(g, w) begin nChecks++; if ((g) !== (w)) begin failures++; \
  $display("unexpected at %0t got %h want %h", $time, g, w); end end

module drive_run_command_generator_test
  import drive_cmd_pkg::*;
;
  logic           clk, rst_b, linkWordWrite, fwdTerminal, revTerminal;
  logic           keyRunFwd, keyRunRev, keyStop, runForward, runReverse;
  logic           linkEnable, localActive, runPermitWait, linearDecelForced;
  logic [1:0]     run, stopKeyPriorityCode, accelPatternCode, decelPattern;
  logic [2:0]     runSourceCode;
  logic [4:0]     generalInput;
  logic [15:0]    linkWordData, linkOperationWordRd, refFrequency;
  logic [15:0]    startingFrequency, stoppingFrequency;
  fn_code_t [4:0] inputFunctionCode;
  fn_code_t       fwdTerminalFunction, revTerminalFunction;
  int             failures, nChecks;
  // gi {local,revAlt,fwdAlt,switch,hold}, terminals {fwd,rev}, run
  typedef struct packed {
    logic [4:0] gi;
    logic [1:0] fr;
    logic [1:0] want;
  } row_t;
  row_t rows [10] = '{'{5'h00, 2'h2, 2'h0}, '{5'h01, 2'h2, 2'h2},
    '{5'h01, 2'h0, 2'h2}, '{5'h00, 2'h0, 2'h0}, '{5'h01, 2'h3, 2'h0},
    '{5'h01, 2'h1, 2'h1}, '{5'h07, 2'h0, 2'h2}, '{5'h03, 2'h0, 2'h0},
    '{5'h0B, 2'h0, 2'h1}, '{5'h10, 2'h2, 2'h0}};
  logic [15:0] words [6] = '{16'h0001, 16'h0002, 16'h2000, 16'h4000,
    16'h6000, 16'h0003};
  logic [1:0] wordRun [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0};

  assign run = {runForward, runReverse};

  operator_panel panel (.clk, .generalInput, .fwdTerminal, .revTerminal,
    .keyRunFwd, .keyRunRev, .keyStop, .linkWordWrite, .linkWordData);
  drive_run_command_generator uut (.clk, .rst_b, .generalInput,
    .fwdTerminal, .revTerminal, .inputFunctionCode, .fwdTerminalFunction,
    .revTerminalFunction, .linkWordWrite, .linkWordData,
    .linkOperationWordRd, .keyRunFwd, .keyRunRev, .keyStop, .runSourceCode,
    .stopKeyPriorityCode, .accelPatternCode, .refFrequency,
    .startingFrequency, .stoppingFrequency, .runForward, .runReverse,
    .linkEnable, .localActive, .runPermitWait, .linearDecelForced,
    .decelPattern);

  // 200 MHz control clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // fixed wait: outputs follow inputs within two edges
  task automatic settle;
    repeat (3) @(posedge clk);
    #2;
  endtask : settle

  // bench-side inputs move at the panel's offset
  task automatic sync;
    @(posedge clk);
    #1;
  endtask : sync

  task automatic print_verdict;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst_b = 1'b0;
    inputFunctionCode = {`FN_LOCAL, `FN_REV_ALT, `FN_FWD_ALT,
                         `FN_SRC_SWITCH, `FN_HOLD3W};
    fwdTerminalFunction = `FN_FWD;
    revTerminalFunction = `FN_REV;
    runSourceCode = `RUN_SRC_TERM;
    stopKeyPriorityCode = 2'h0;
    accelPatternCode = 2'h2;
    refFrequency = 16'h1000;
    startingFrequency = 16'h0100;
    stoppingFrequency = 16'h0080;
    failures = 0;
    nChecks = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    foreach (rows[i]) begin
      panel.put(rows[i].gi, rows[i].fr, 3'h0);
      settle();
      `CHK(run, rows[i].want)
    end
    // reset in mid-run with a command held
    panel.put(5'h01, 2'h2, 3'h0);
    settle();
    `CHK(run, 2'h2)
    sync();
    rst_b = 1'b0;
    settle();
    `CHK({run, linkEnable, linkOperationWordRd}, 19'h0)
    sync();
    rst_b = 1'b1;
    panel.put(5'h00, 2'h0, 3'h0);
    foreach (words[i]) begin
      panel.send(words[i]);
      settle();
      `CHK(linkOperationWordRd, words[i])
      `CHK(run, wordRun[i])
      `CHK(linkEnable, 1'b1)
    end
    // local select overrides a set link word
    panel.put(5'h10, 2'h0, 3'h0);
    settle();
    `CHK({linkEnable, localActive}, 2'h1)
    panel.send(16'h0000);
    panel.put(5'h00, 2'h0, 3'h0);
    settle();
    `CHK(linkEnable, 1'b0)
    // keypad: run held after key release until stop
    sync();
    runSourceCode = 3'h0;
    panel.put(5'h00, 2'h0, 3'h4);
    panel.put(5'h00, 2'h0, 3'h0);
    settle();
    `CHK(run, 2'h2)
    panel.put(5'h00, 2'h0, 3'h1);
    panel.put(5'h00, 2'h0, 3'h0);
    settle();
    `CHK(run, 2'h0)
    sync();
    runSourceCode = `RUN_SRC_TERM;
    // stop key only wins over terminals for codes 1 and 3
    for (int k = 0; k < 4; k++) begin
      sync();
      stopKeyPriorityCode = 2'(k);
      panel.put(5'h01, 2'h2, 3'h0);
      settle();
      panel.put(5'h01, 2'h2, 3'h1);
      settle();
      `CHK({run, linearDecelForced}, k[0] ? 3'h1 : 3'h4)
      `CHK(decelPattern, k[0] ? 2'h0 : 2'h2)
      panel.put(5'h00, 2'h0, 3'h0);
      settle();
    end
    // boundary of the starting and stopping frequencies
    panel.put(5'h01, 2'h2, 3'h0);
    refFrequency = 16'h00FF;
    settle();
    `CHK(run, 2'h0)
    sync();
    refFrequency = 16'h0100;
    settle();
    `CHK(run, 2'h2)
    sync();
    stoppingFrequency = 16'h0101;
    settle();
    `CHK(run, 2'h0)
    sync();
    refFrequency = 16'h1000;
    // permit must come first; with no hold a pulse is not kept
    panel.put(5'h00, 2'h0, 3'h0);
    inputFunctionCode[0] = `FN_RUN_PERMIT;
    panel.put(5'h00, 2'h2, 3'h0);
    settle();
    `CHK({run, runPermitWait}, 3'h1)
    panel.put(5'h01, 2'h2, 3'h0);
    settle();
    `CHK(run, 2'h0)
    panel.put(5'h01, 2'h0, 3'h0);
    settle();
    panel.put(5'h01, 2'h2, 3'h0);
    settle();
    `CHK(run, 2'h2)
    panel.put(5'h01, 2'h0, 3'h0);
    settle();
    `CHK(run, 2'h0)
    // permit on two inputs: the idle one must not mask the other
    sync();
    inputFunctionCode[1] = `FN_RUN_PERMIT;
    panel.put(5'h02, 2'h0, 3'h0);
    panel.put(5'h02, 2'h2, 3'h0);
    settle();
    `CHK(run, 2'h2)
    print_verdict();
  end
endmodule : drive_run_command_generator_test
